// File: nio_pkg.sv
// Package for the nibble I/O expander: opcodes, port codes, reset values.
// Assumes a single 200 MHz system clock in the enclosing design.
package nio_pkg;

	localparam int NIO_NIB_W = 4;
	localparam int NIO_NUM_PORTS = 4;

	// Operation codes in the upper two bits of the first nibble
	typedef enum logic [1:0] {
		NIO_OP_READ = 2'b00,
		NIO_OP_DIRECT = 2'b01,
		NIO_OP_OR = 2'b10,
		NIO_OP_AND = 2'b11
	} nio_op_t;

	// Field positions in the first nibble
	localparam int NIO_OP_MSB = 3;
	localparam int NIO_OP_LSB = 2;
	localparam int NIO_ADDR_MSB = 1;
	localparam int NIO_ADDR_LSB = 0;

	// Reset values
	localparam logic [3:0] NIO_LATCH_RST = 4'h0;
	localparam logic [1:0] NIO_ADDR_RST = 2'h0;

	// Transfer phase machine
	typedef enum logic [1:0] {
		NIO_ST_POWERON = 2'b00,
		NIO_ST_IDLE = 2'b01,
		NIO_ST_DATA = 2'b10
	} nio_state_t;

endpackage

// File: nio_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module nio_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Pins in, synchronised out
	input wire logic [W-1:0] i_async,
	input wire logic [W-1:0] i_rst_val,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage; bits are held relative to
	// i_rst_val so a zero reset leaves each output at its own idle level
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async ^ i_rst_val;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q ^ i_rst_val;
endmodule

// File: nio_port.sv
// One expansion port: output latch, write combiner and drive enable.
// Assumes load strobes are one-cycle pulses on i_clk.
`timescale 1ns/1ps
module nio_port
	import nio_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Control from the transfer engine
	input wire logic i_wr,
	input wire logic i_rd,
	input wire nio_op_t i_op,
	input wire logic [3:0] i_data,
	// Port state
	output logic [3:0] o_latch,
	output logic o_oe
);
	logic [3:0] latch_q;
	logic [3:0] latch_d;
	logic oe_q;

	// direct replace, OR merge, AND merge
	assign latch_d = (i_op == NIO_OP_OR) ? (latch_q | i_data) :
		(i_op == NIO_OP_AND) ? (latch_q & i_data) : i_data;

	// drive latch after write until read; read floats the port
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			latch_q <= NIO_LATCH_RST;
			oe_q <= 1'b0;
		end else if (i_wr) begin
			latch_q <= latch_d;
			oe_q <= 1'b1;
		end else if (i_rd) begin
			oe_q <= 1'b0;
		end
	end

	assign o_latch = latch_q;
	assign o_oe = oe_q;

	a_port_write_drive: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_wr |=> (o_oe && o_latch == $past(latch_d)))
		else $error("port latch not loaded on write");
	a_port_or_merge: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(i_wr && i_op == NIO_OP_OR) |=>
		((o_latch & $past(latch_q)) == $past(latch_q)))
		else $error("or write lost a set bit");
	a_port_and_merge: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(i_wr && i_op == NIO_OP_AND) |=>
		((o_latch & ~$past(latch_q)) == 4'h0))
		else $error("and write set a clear bit");
	a_port_read_float: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(i_rd && !i_wr) |=> !o_oe)
		else $error("port still driven after read");
endmodule

// File: nio_expander.sv
// Nibble I/O expander: four 4-bit ports behind a strobed nibble bus.
// Assumes strobe, select and pins are asynchronous and far slower than
// i_clk; edges are found after a two-flop synchroniser.
// Function
// - A transfer is an opcode/address nibble then a data nibble.
// - Strobe falling edge latches opcode and port address.
// - Upper bits: 00 read, 01 direct, 10 OR, 11 AND write.
// - Lower bits select port a, b, c or d.
// - Write data is taken at the strobe rising edge.
// - Read drives the selected port input onto the bus before rising edge.
// - Decoded read floats the selected port and enables its input.
// - Rising edge ends read; bus back to input, port stays floating.
// - Direct write replaces the port latch.
// - OR-write latches new data OR old latch.
// - AND-write latches new data AND old latch.
// - After a write the port drives its latch until a read of that port.
// - Chip select high freezes port outputs and state; bus output enable drops.
// - At power-up ports float and bus is input.
// - Stay in power-on state until the first strobe falling edge.
`timescale 1ns/1ps
module nio_expander
	import nio_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Host side
	input wire logic i_transfer_strobe,
	input wire logic i_chip_sel_n,
	input wire logic [3:0] i_host_nibble_bus,
	output logic [3:0] o_host_nibble_bus,
	output logic o_host_nibble_bus_oe,
	// Expansion port a
	input wire logic [3:0] i_expansion_port_a,
	output logic [3:0] o_expansion_port_a,
	output logic o_expansion_port_a_oe,
	// Expansion port b
	input wire logic [3:0] i_expansion_port_b,
	output logic [3:0] o_expansion_port_b,
	output logic o_expansion_port_b_oe,
	// Expansion port c
	input wire logic [3:0] i_expansion_port_c,
	output logic [3:0] o_expansion_port_c,
	output logic o_expansion_port_c_oe,
	// Expansion port d
	input wire logic [3:0] i_expansion_port_d,
	output logic [3:0] o_expansion_port_d,
	output logic o_expansion_port_d_oe
);
	localparam int SW = 2 + 4 + 16;

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [SW-1:0] sync_out;
	logic strobe_s;
	logic csn_s;
	logic [3:0] bus_s;
	logic [15:0] pins_s;

	// Select resets inactive; strobe resets low so a pin high at release
	// only gives a rise, which the power-on state ignores
	nio_sync #(.W(SW)) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_async({i_transfer_strobe, i_chip_sel_n, i_host_nibble_bus,
			i_expansion_port_d, i_expansion_port_c,
			i_expansion_port_b, i_expansion_port_a}),
		.i_rst_val({2'b01, 20'h0}),
		.o_sync(sync_out)
	);
	// Synchroniser output is the pin level; only its reset value differs
	assign strobe_s = sync_out[21];
	assign csn_s = sync_out[20];
	assign bus_s = sync_out[19:16];
	assign pins_s = sync_out[15:0];

	// ==========================================================
	// Edge detection and transfer state
	// ==========================================================
	logic strobe_q;
	logic fall;
	logic rise;
	nio_state_t state_q;
	nio_state_t state_d;
	nio_op_t op_q;
	logic [1:0] addr_q;
	logic [3:0] rd_data_q;
	logic [3:0] port_wr;
	logic [3:0] port_rd;
	logic [3:0] sel_dec;
	logic [3:0] sel_pin;
	logic [3:0] sel_latch;
	logic [3:0] latch [4];
	logic [3:0] oe;
	logic sel;

	assign sel = ~csn_s;
	assign fall = sel && strobe_q && !strobe_s;
	assign rise = sel && !strobe_q && strobe_s;

	// Strobe history tracks even when deselected so reselection is clean
	// Resets low: a strobe low at power-up makes no false fall
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe_s;
		end
	end

	// Power-on state left only on a falling edge; two phases
	always_comb begin
		state_d = state_q;
		case (state_q)
			NIO_ST_POWERON: begin
				if (fall) state_d = NIO_ST_DATA;
			end
			NIO_ST_IDLE: begin
				if (fall) state_d = NIO_ST_DATA;
			end
			NIO_ST_DATA: begin
				if (rise) state_d = NIO_ST_IDLE;
				else if (fall) state_d = NIO_ST_DATA;
			end
			default: state_d = NIO_ST_POWERON;
		endcase
	end

	// Latch opcode and address on falling edge; fields
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= NIO_ST_POWERON;
			op_q <= NIO_OP_READ;
			addr_q <= NIO_ADDR_RST;
		end else begin
			state_q <= state_d;
			if (fall) begin
				op_q <= nio_op_t'(bus_s[NIO_OP_MSB:NIO_OP_LSB]);
				addr_q <= bus_s[NIO_ADDR_MSB:NIO_ADDR_LSB];
			end
		end
	end

	// ==========================================================
	// Port decode and per-port latches
	// ==========================================================
	// One-hot port select from the latched address
	assign sel_dec = 4'h1 << addr_q;
	// Write data taken from the bus at the rising edge
	assign port_wr = (state_q == NIO_ST_DATA && rise && op_q != NIO_OP_READ)
		? sel_dec : 4'h0;
	// Read floats the selected port as soon as it is decoded
	// gated by select so a deselected read changes nothing
	assign port_rd = (state_q == NIO_ST_DATA && op_q == NIO_OP_READ &&
		sel) ? sel_dec : 4'h0;
	// Latch of the addressed port, watched by the write checks
	assign sel_latch = latch[addr_q];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_port
			nio_port u_port (
				.i_clk(i_clk),
				.i_nrst(i_nrst),
				.i_wr(port_wr[g]),
				.i_rd(port_rd[g]),
				.i_op(op_q),
				.i_data(bus_s),
				.o_latch(latch[g]),
				.o_oe(oe[g])
			);
		end
	endgenerate

	// ==========================================================
	// Read data path
	// ==========================================================
	// Selected port pins chosen for the bus
	assign sel_pin = pins_s[addr_q*4 +: 4];

	// Sample continuously during the read so the bus settles early
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_data_q <= NIO_LATCH_RST;
		end else if (|port_rd) begin
			rd_data_q <= sel_pin;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Bus driven only in a selected read data phase
	assign o_host_nibble_bus_oe = (state_q == NIO_ST_DATA) &&
		(op_q == NIO_OP_READ) && sel;
	assign o_host_nibble_bus = rd_data_q;
	// Ports float from reset because every port enable resets low
	assign o_expansion_port_a = latch[0];
	assign o_expansion_port_a_oe = oe[0];
	assign o_expansion_port_b = latch[1];
	assign o_expansion_port_b_oe = oe[1];
	assign o_expansion_port_c = latch[2];
	assign o_expansion_port_c_oe = oe[2];
	assign o_expansion_port_d = latch[3];
	assign o_expansion_port_d_oe = oe[3];

	// ==========================================================
	// Checks
	// ==========================================================
	// All checks watch synchronised signals, so pin skew stays out of them
	// Quiet in power-on
	a_poweron_quiet: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(state_q == NIO_ST_POWERON) |->
		(oe == 4'h0 && !o_host_nibble_bus_oe))
		else $error("driving in power-on state");
	a_poweron_exit: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(state_q == NIO_ST_POWERON && !fall) |=>
		(state_q == NIO_ST_POWERON))
		else $error("left power-on without falling edge");
	a_desel_freeze: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		csn_s |=> ($stable(oe) && $stable(state_q) &&
		$stable(op_q) && $stable(rd_data_q)))
		else $error("state changed while deselected");
	a_desel_ports: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		csn_s |=> ($stable(o_expansion_port_a) &&
		$stable(o_expansion_port_b) && $stable(o_expansion_port_c) &&
		$stable(o_expansion_port_d)))
		else $error("port output changed while deselected");
	a_fall_capture: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		fall |=> (op_q == $past(bus_s[3:2]) &&
		addr_q == $past(bus_s[1:0])))
		else $error("opcode not captured at falling edge");
	a_read_no_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(op_q == NIO_OP_READ) |-> (port_wr == 4'h0))
		else $error("read opcode wrote a port");
	a_one_port: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		$onehot0(port_wr | port_rd))
		else $error("more than one port selected");
	a_read_bus_drive: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(fall && bus_s[3:2] == 2'b00) |=> ##1 (o_host_nibble_bus_oe &&
		o_host_nibble_bus == $past(sel_pin)))
		else $error("read data not on bus");
	a_rise_release: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rise |=> !o_host_nibble_bus_oe)
		else $error("bus still driven after read end");
	a_read_end_float: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(rise && |port_rd) |=> ((oe & $past(port_rd)) == 4'h0))
		else $error("read port driven after read end");
	a_read_floats: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(fall && bus_s[3:2] == 2'b00) |=> ##1 (oe[addr_q] == 1'b0))
		else $error("read port still driven");
	a_bus_only_read: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		o_host_nibble_bus_oe |-> (op_q == NIO_OP_READ))
		else $error("bus driven outside read");
	a_write_port: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(|port_wr) |=> (oe & $past(port_wr)) == $past(port_wr))
		else $error("written port not driving");
	a_direct_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(|port_wr && op_q == NIO_OP_DIRECT) |=>
		(sel_latch == $past(bus_s)))
		else $error("direct write value wrong");
	a_or_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(|port_wr && op_q == NIO_OP_OR) |=>
		(sel_latch == ($past(sel_latch) | $past(bus_s))))
		else $error("or write value wrong");
	a_and_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(|port_wr && op_q == NIO_OP_AND) |=>
		(sel_latch == ($past(sel_latch) & $past(bus_s))))
		else $error("and write value wrong");
endmodule

// File: nio_host_model.sv
// Host model for the nibble I/O expander: drives strobe, select and bus.
// Assumes one free-running clock; all pins change just after its edge.
`timescale 1ns/1ps
// ==========================================
// Host side of the strobed nibble bus
module nio_host_model (
	// Clock
	input wire logic i_clk,
	// Device bus drive
	input wire logic [3:0] i_dev_bus,
	input wire logic i_dev_oe,
	// Host pins
	output logic o_strobe,
	output logic o_cs_n,
	output logic [3:0] o_bus
);
	logic [3:0] hv;

	// Strobe starts high; the first selected fall leaves the power-on state
	initial begin
		o_strobe = 1'b1;
		o_cs_n = 1'b1;
		hv = 4'h5;
	end

	// Released bus shows inverted last value; for the port c read that is D, its expected pin value
	assign o_bus = i_dev_oe ? i_dev_bus : hv;

	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// One transfer; eight clocks per phase keeps setup and hold margins
	task automatic xfer(input logic sel, input logic [3:0] code,
		input logic [3:0] d, input logic rd, output logic [3:0] q);
		wt(1);
		o_cs_n <= ~sel;
		hv <= code;
		wt(8);
		o_strobe <= 1'b0;
		wt(8);
		if (rd) begin
			hv <= ~hv;
		end else begin
			hv <= d;
		end
		wt(8);
		q = o_bus;
		o_strobe <= 1'b1;
		wt(8);
		hv <= ~hv;
		o_cs_n <= 1'b1;
		wt(4);
	endtask
endmodule

// File: nio_expander_test.sv
// Self-checking bench for the nibble I/O expander.
// Assumes nio_pkg and the host model are compiled first.
`timescale 1ns/1ps
// ==========================================
// Bench top
module nio_expander_test;
	import nio_pkg::*;
	logic i_clk;
	logic i_nrst;
	logic strobe;
	logic cs_n;
	logic [3:0] hbus;
	logic [3:0] dbus;
	logic doe;
	logic [3:0] ext [4];
	logic [3:0] pin_o [4];
	logic [3:0] pin_i [4];
	logic [3:0] poe;
	logic [3:0] q;
	int err_total;
	int total_checks;
	int cyc;

	// Port pins resolve between device drive and the outside world
	for (genvar k = 0; k < 4; k++) begin : g_pin
		assign pin_i[k] = poe[k] ? pin_o[k] : ext[k];
	end

	nio_host_model i_host (.i_clk(i_clk), .i_dev_bus(dbus), .i_dev_oe(doe),
		.o_strobe(strobe), .o_cs_n(cs_n), .o_bus(hbus));

	nio_expander i_dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_transfer_strobe(strobe), .i_chip_sel_n(cs_n),
		.i_host_nibble_bus(hbus), .o_host_nibble_bus(dbus),
		.o_host_nibble_bus_oe(doe),
		.i_expansion_port_a(pin_i[0]), .o_expansion_port_a(pin_o[0]),
		.o_expansion_port_a_oe(poe[0]),
		.i_expansion_port_b(pin_i[1]), .o_expansion_port_b(pin_o[1]),
		.o_expansion_port_b_oe(poe[1]),
		.i_expansion_port_c(pin_i[2]), .o_expansion_port_c(pin_o[2]),
		.o_expansion_port_c_oe(poe[2]),
		.i_expansion_port_d(pin_i[3]), .o_expansion_port_d(pin_o[3]),
		.o_expansion_port_d_oe(poe[3]));

	// ==========================================
	// Checking and closing
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_power();
		check(poe, 4'h0);
		check({3'h0, doe}, 4'h0);
		i_host.xfer(1'b0, {NIO_OP_DIRECT, 2'h0}, 4'hF, 1'b0, q);
		check(poe, 4'h0);
		check(pin_o[0], 4'h0);
	endtask

	// Direct, OR, AND, then a distinct direct value per port, so OR cannot
	// pass for replace and a stray write to another port shows
	task automatic t_write();
		for (int p = 0; p < 4; p++) begin
			i_host.xfer(1'b1, {NIO_OP_DIRECT, 2'(p)}, 4'h6, 1'b0, q);
			check(pin_o[p], 4'h6);
			check({3'h0, poe[p]}, 4'h1);
			i_host.xfer(1'b1, {NIO_OP_OR, 2'(p)}, 4'h9, 1'b0, q);
			check(pin_o[p], 4'hF);
			i_host.xfer(1'b1, {NIO_OP_AND, 2'(p)}, 4'h3, 1'b0, q);
			check(pin_o[p], 4'h3);
			i_host.xfer(1'b1, {NIO_OP_DIRECT, 2'(p)}, 4'(8 + p), 1'b0, q);
			check(pin_o[p], 4'(8 + p));
		end
		for (int p = 0; p < 4; p++) begin
			check(pin_o[p], 4'(8 + p));
		end
	endtask

	task automatic t_freeze();
		i_host.xfer(1'b0, {NIO_OP_DIRECT, 2'h1}, 4'h1, 1'b0, q);
		check(pin_o[1], 4'h9);
		i_host.xfer(1'b0, {NIO_OP_READ, 2'h0}, 4'h0, 1'b1, q);
		check(poe, 4'hF);
	endtask

	// First read after writes is thrown away, as the host must
	task automatic t_read();
		for (int p = 0; p < 4; p++) begin
			i_host.xfer(1'b1, {NIO_OP_READ, 2'(p)}, 4'h0, 1'b1, q);
			i_host.xfer(1'b1, {NIO_OP_READ, 2'(p)}, 4'h0, 1'b1, q);
			check(q, ext[p]);
			check({3'h0, poe[p]}, 4'h0);
			check({3'h0, doe}, 4'h0);
		end
		check(poe, 4'h0);
	endtask

	// ==========================================
	// Clock, timeout and main sequence
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		i_nrst = 1'b0;
		ext[0] = 4'h2;
		ext[1] = 4'h7;
		ext[2] = 4'hD;
		ext[3] = 4'h4;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clk);
		t_power();
		t_write();
		t_freeze();
		t_read();
		finish_test();
	end
endmodule
